// File: bench/prcm_sva.sv
`timescale 1ns/10ps
`default_nettype none
module prcm_sva (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Line
  input wire logic lnk_data,
  input wire logic lnk_stb,
  input wire logic lnk_fsync,
  // Configuration
  input wire logic I_REMOTE_ALARM,
  input wire logic I_LAYOUT_32K,
  input wire logic [3:0] I_GRP_CAS
);
  localparam logic [11:0] EXP_MARK = 12'h8DC;
  logic [7:0] gap_q;
  logic [7:0] pos_q;
  logic [7:0] pos_now;
  logic [3:0] frm_q;
  logic [3:0] frm_now;
  logic [5:0] cfg0_q;
  logic [5:0] cfg1_q;
  logic [5:0] cfg_w;
  logic stab_w;
  logic [1:0] grp_w;
  logic gch_w;

  // ------
  // Line position tracking
  // ------
  // Config must be steady over a whole frame, since the ends may latch it at frame start
  assign cfg_w = {I_REMOTE_ALARM, I_LAYOUT_32K, I_GRP_CAS};
  assign stab_w = (cfg0_q == cfg_w) && (cfg1_q == cfg_w);
  assign frm_now = (pos_q == 8'h00) ? 4'h0 : (frm_q == 4'hB) ? 4'h0 : frm_q + 4'h1;
  assign pos_now = lnk_fsync ? 8'h01 : pos_q + 8'h01;
  assign grp_w = 2'((pos_now - 8'h31) / 8'h30);
  assign gch_w = lnk_stb && stab_w && I_LAYOUT_32K && (pos_q != 8'h00) &&
                 (pos_now inside {8'h31, 8'h61, 8'h91, 8'hC1}) && I_GRP_CAS[grp_w];

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      gap_q <= 8'h00;
      pos_q <= 8'h00;
      frm_q <= 4'h0;
      cfg0_q <= 6'h00;
      cfg1_q <= 6'h00;
    end else begin
      if (lnk_stb) begin
        gap_q <= 8'h01;
        pos_q <= pos_now;
      end else if (gap_q != 8'hFF && gap_q != 8'h00) begin
        gap_q <= gap_q + 8'h01;
      end
      if (lnk_fsync) begin
        frm_q <= frm_now;
        cfg0_q <= cfg_w;
        cfg1_q <= cfg0_q;
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  stb_space_a: assert property (lnk_stb |-> gap_q inside {8'h00, 8'h10, 8'h11})
    else $error("line strobe spacing out of range");
  data_hold_a: assert property (lnk_stb |=> (!lnk_stb && $stable(lnk_data)) [*8])
    else $error("line bit not held after strobe");
  frame_len_a: assert property (lnk_fsync |-> pos_q inside {8'h00, 8'hC1})
    else $error("frame length is not 193 bits");
  first_frame_a: assert property (lnk_stb && pos_q == 8'h00 |-> lnk_fsync)
    else $error("first line bit is not a marker");
  fsync_stb_a: assert property (lnk_fsync |-> lnk_stb)
    else $error("frame start without strobe");
  marker_seq_a: assert property (lnk_fsync && frm_now != 4'hB |-> lnk_data == EXP_MARK[4'hB - frm_now])
    else $error("marker bit pattern wrong");
  remote_alarm_a: assert property (lnk_fsync && frm_now == 4'hB && stab_w |-> lnk_data == I_REMOTE_ALARM)
    else $error("frame 12 marker does not follow alarm");
  gch_spare_a: assert property (gch_w |-> lnk_data)
    else $error("group channel fourth bit not one");

  alarm_sent_c: cover property (lnk_fsync && frm_now == 4'hB && lnk_data);
  gch_seen_c: cover property (gch_w);
  frame_32k_c: cover property (lnk_fsync && I_LAYOUT_32K);
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lay32 = 1'b0;
  logic mf24 = 1'b0;
  prcm_pkg::prcm_sig_type sig_mode = prcm_pkg::SIG_ABCD;
  logic [3:0] grp_cas = 4'h0;
  logic alarm = 1'b0;
  logic [3:0] gch_alarm = 4'h0;
  logic [3:0] gch_alarm_rx;
  logic gch_lock;
  logic [prcm_pkg::SIG_W-1:0] sig_tx = '1;
  logic [prcm_pkg::SIG_W-1:0] sig_rx;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_ready, mf_lock, rx_alarm, rx_valid;
  logic [7:0] rx_data;
  logic [7:0] mask;
  logic [5:0] rx_slot;
  logic [7:0] exp_q[$];
  integer seed = 32'hFA87;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  prcm_link_if link_if ();
  prcm_tx prcm_tx_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_LAYOUT_32K(lay32), .I_MF24(mf24),
    .I_SIG_MODE(sig_mode), .I_GRP_CAS(grp_cas), .I_REMOTE_ALARM(alarm),
    .I_GCH_ALARM(gch_alarm), .I_SIG_ABCD(sig_tx), .I_TX_DATA(tx_data),
    .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .LINK(link_if.tx));
  prcm_rx prcm_rx_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_LAYOUT_32K(lay32), .I_MF24(mf24),
    .I_GRP_CAS(grp_cas), .LINK(link_if.rx), .O_MF_LOCK(mf_lock), .O_GCH_LOCK(gch_lock),
    .O_REMOTE_ALARM(rx_alarm), .O_GCH_ALARM(gch_alarm_rx), .O_SIG_ABCD(sig_rx),
    .O_RX_DATA(rx_data), .O_RX_SLOT(rx_slot), .O_RX_VALID(rx_valid));
  prcm_sva prcm_sva_inst (.I_CLK_SYS(clk), .I_RST(rst), .lnk_data(link_if.lnk_data),
    .lnk_stb(link_if.lnk_stb), .lnk_fsync(link_if.lnk_fsync), .I_REMOTE_ALARM(alarm),
    .I_LAYOUT_32K(lay32), .I_GRP_CAS(grp_cas));

  // ------
  // Shared tasks
  // ------
  // Robbed bit 8 makes the octet LSB unpredictable in signalling frames
  assign mask = lay32 ? 8'h0F : 8'hFE;

  always #20 clk = ~clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] time %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_fsync(input int n);
    repeat (n) @(posedge clk iff link_if.lnk_fsync === 1'b1);
    @(negedge clk);
  endtask

  task automatic push(input logic [7:0] w);
    logic rdy;
    tx_data = w;
    tx_valid = 1'b1;
    do begin
      rdy = (tx_ready === 1'b1);
      @(negedge clk);
    end while (!rdy);
    exp_q.push_back(w & mask);
  endtask

  // Starts just after a marker bit, so no slot pops the FIFO while it fills
  task automatic burst(input int n);
    wait_fsync(1);
    for (int k = 0; k < n; k++) begin
      push(8'($random(seed)) & (lay32 ? 8'h77 : 8'h7F));
      if (k == 3) begin
        tx_valid = 1'b0;
        @(negedge clk);
        check({7'h0, tx_ready}, 8'h00);
      end
    end
    tx_valid = 1'b0;
  endtask

  task automatic drain();
    for (int k = 0; k < 4000 && exp_q.size() != 0; k++) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
  endtask

  // ------
  // Receive side comparison
  // ------
  // Idle words have their top bit set; test words never do
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      check({7'h0, lay32 && grp_cas[rx_slot / 6'h0C] && (rx_slot % 6'h0C == 6'h0B)}, 8'h00);
      if ((lay32 ? rx_data[3] : rx_data[7]) !== 1'b1) begin
        check(rx_data & mask, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hFF);
      end
    end
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 100000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 6; k++) sig_tx[k * 32 +: 32] = $random(seed);
    wait_fsync(1);
    sig_mode = prcm_pkg::SIG_A;
    for (int k = 0; k < 16 && mf_lock !== 1'b1; k++) wait_fsync(1);
    check({7'h0, mf_lock}, 8'h01);
    check({7'h0, rx_alarm}, 8'h00);
    alarm = 1'b1;
    repeat (12) burst(6);
    for (int ch = 0; ch < 24; ch++) check({6'h0, sig_rx[ch*4+1], sig_rx[ch*4]}, {6'h0, {2{sig_tx[ch*4]}}});
    check({7'h0, rx_alarm}, 8'h01);
    check({7'h0, mf_lock}, 8'h01);
    drain();
    $display("robbed-bit signalling and 64k traffic test done");
    wait_fsync(1);
    lay32 = 1'b1;
    grp_cas = {2'($random(seed)), 2'b01};
    sig_mode = prcm_pkg::SIG_AB;
    sig_tx = '1;
    alarm = 1'b0;
    gch_alarm = 4'($random(seed));
    // Both ends switch counting together; lock must survive the change
    mf24 = 1'b1;
    repeat (4) burst(6);
    drain();
    // Too few frames for the 24-frame group alignment to be found
    check({7'h0, gch_lock}, 8'h00);
    check({4'h0, gch_alarm_rx}, 8'h00);
    check({7'h0, mf_lock}, 8'h01);
    $display("32k grouping traffic test done");
    finish_test();
  end
endmodule
`default_nettype wire

// File: core/prcm_rx.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Receiving framer
// ----------------------------------------------------------------
module prcm_rx (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Configuration
  input wire logic I_LAYOUT_32K,
  input wire logic I_MF24,
  input wire logic [3:0] I_GRP_CAS,
  // Line
  prcm_link_if.rx LINK,
  // Status
  output logic O_MF_LOCK,
  output logic O_GCH_LOCK,
  output var logic O_REMOTE_ALARM,
  output var logic [3:0] O_GCH_ALARM,
  output var logic [prcm_pkg::SIG_W-1:0] O_SIG_ABCD,
  // Traffic out
  output var logic [prcm_pkg::DATA_W-1:0] O_RX_DATA,
  output var logic [5:0] O_RX_SLOT,
  output var logic O_RX_VALID
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  prcm_pkg::prcm_lock_type mst_q;
  prcm_pkg::prcm_lock_type gst_q;
  logic [7:0] pos_q;
  logic [4:0] mcnt_q;
  logic [4:0] gcnt_q;
  logic [11:0] mhist_q;
  logic [23:0] ghist_q;
  logic [6:0] sh_q;

  // ----------------------------------------------------------------
  // Position decode
  // ----------------------------------------------------------------
  wire logic stb = LINK.lnk_stb;
  wire logic d = LINK.lnk_data;
  wire logic [7:0] cur_pos = LINK.lnk_fsync ? 8'h00 : pos_q;
  wire logic marker_pos = (cur_pos == 8'h00);
  wire logic [7:0] p_w = cur_pos - 8'h01;
  wire logic [5:0] slot_w = I_LAYOUT_32K ? p_w[7:2] : {1'b0, p_w[7:3]};
  wire logic [2:0] bi_w = I_LAYOUT_32K ? {1'b0, p_w[1:0]} : p_w[2:0];
  wire logic [2:0] bi_last = I_LAYOUT_32K ? prcm_pkg::BIT_LAST_32 : prcm_pkg::BIT_LAST_64;
  wire logic [1:0] grp_w = prcm_pkg::grp_of(slot_w);
  wire logic is_gch = I_LAYOUT_32K && I_GRP_CAS[grp_w] && prcm_pkg::gch_slot(slot_w);
  // Alignment is taken from the lowest grouping that carries signalling
  wire logic [1:0] ref_grp = I_GRP_CAS[0] ? 2'h0 : I_GRP_CAS[1] ? 2'h1 : I_GRP_CAS[2] ? 2'h2 : 2'h3;
  wire logic ref_gch = is_gch && (grp_w == ref_grp);
  wire logic [1:0] ltr_last = I_MF24 ? prcm_pkg::LTR_LAST_24 : prcm_pkg::LTR_LAST_12;

  // ----------------------------------------------------------------
  // Marker lock; frame 12 marker bit is masked for the alarm
  // ----------------------------------------------------------------
  wire logic [11:0] mhist_d = {mhist_q[10:0], d};
  wire logic m_match = (mhist_d[11:1] == prcm_pkg::MARK_SEQ[11:1]);
  wire logic [4:0] m_inc = prcm_pkg::mf_next(mcnt_q, ltr_last);
  wire logic m_inc_f12 = m_inc[3] && (m_inc[2:0] == prcm_pkg::PAIR_LAST);
  wire logic m_hunt_hit = (mst_q == prcm_pkg::ST_HUNT) && m_match;
  wire logic m_sync = (mst_q == prcm_pkg::ST_SYNC);
  wire logic m_drop = m_sync && m_inc_f12 && !m_match;

  // ----------------------------------------------------------------
  // Group channel lock
  // ----------------------------------------------------------------
  wire logic [23:0] ghist_d = {ghist_q[22:0], d};
  wire logic g_match = (ghist_d == prcm_pkg::GCH_SEQ);
  wire logic g_sync = (gst_q == prcm_pkg::ST_SYNC);
  wire logic g_f24 = (gcnt_q == {prcm_pkg::LTR_LAST_24, prcm_pkg::PAIR_LAST});
  wire logic g_align = stb && ref_gch && (bi_w == 3'h2);

  // ----------------------------------------------------------------
  // Signalling capture, letters stored as received
  // ----------------------------------------------------------------
  wire logic [5:0] ch1 = prcm_pkg::grp_base(grp_w) + {2'b00, gcnt_q[2:0], 1'b0};
  wire logic g_pair_last = (gcnt_q[2:0] == prcm_pkg::PAIR_LAST);
  wire logic rob_we = m_sync && !I_LAYOUT_32K && (mcnt_q[2:0] == prcm_pkg::PAIR_LAST)
                      && (bi_w == prcm_pkg::BIT_LAST_64) && !marker_pos;
  wire logic gch_b1_we = g_sync && is_gch && (bi_w == 3'h0);
  wire logic gch_b2_we = g_sync && is_gch && (bi_w == 3'h1) && !g_pair_last;
  wire logic sig_we = stb && (rob_we || gch_b1_we || gch_b2_we);
  wire logic [7:0] sig_idx = rob_we ? {slot_w, mcnt_q[4:3]}
                           : gch_b1_we ? {ch1, gcnt_q[4:3]} : {ch1[5:1], 1'b1, gcnt_q[4:3]};
  wire logic alarm_we = stb && g_sync && ref_gch && (bi_w == 3'h1) && g_pair_last;
  wire logic slot_done = stb && !marker_pos && (bi_w == bi_last) && !is_gch;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mst_q <= prcm_pkg::ST_HUNT;
      gst_q <= prcm_pkg::ST_HUNT;
      pos_q <= '0;
      mcnt_q <= '0;
      gcnt_q <= '0;
      mhist_q <= '0;
      ghist_q <= '0;
      sh_q <= '0;
      O_REMOTE_ALARM <= 1'b0;
      O_GCH_ALARM <= '0;
      O_SIG_ABCD <= '0;
      O_RX_DATA <= '0;
      O_RX_SLOT <= '0;
      O_RX_VALID <= 1'b0;
    end else begin
      O_RX_VALID <= slot_done;
      if (stb) begin
        pos_q <= (cur_pos == prcm_pkg::LAST_POS) ? 8'h00 : cur_pos + 8'h01;
        sh_q <= {sh_q[5:0], d};
      end
      if (stb && marker_pos) begin
        mhist_q <= mhist_d;
        gcnt_q <= prcm_pkg::mf_next(gcnt_q, prcm_pkg::LTR_LAST_24);
        // Relock only from hunt so a 24-frame count is not cut at 12
        mcnt_q <= m_hunt_hit ? {prcm_pkg::LTR_LAST_12, prcm_pkg::PAIR_LAST} : m_inc;
        if (m_hunt_hit) begin
          mst_q <= prcm_pkg::ST_SYNC;
        end else if (m_drop) begin
          mst_q <= prcm_pkg::ST_HUNT;
        end
        if (m_hunt_hit || (m_sync && m_inc_f12)) begin
          O_REMOTE_ALARM <= d;
        end
      end
      if (g_align) begin
        ghist_q <= ghist_d;
        if (!g_sync && g_match) begin
          gst_q <= prcm_pkg::ST_SYNC;
          gcnt_q <= {prcm_pkg::LTR_LAST_24, prcm_pkg::PAIR_LAST};
        end else if (g_sync && g_f24 && !g_match) begin
          gst_q <= prcm_pkg::ST_HUNT;
        end
      end
      if (sig_we) begin
        O_SIG_ABCD[sig_idx] <= d;
      end
      if (alarm_we) begin
        O_GCH_ALARM[gcnt_q[4:3]] <= d;
      end
      if (slot_done) begin
        O_RX_SLOT <= slot_w;
        O_RX_DATA <= I_LAYOUT_32K ? {4'h0, sh_q[2:0], d} : {sh_q, d};
      end
    end
  end

  assign O_MF_LOCK = mst_q[1];
  assign O_GCH_LOCK = gst_q[1];

endmodule
`default_nettype wire

// File: core/prcm_tx.sv
// What this block does
// - 32k slots hold four bits, sent 1 to 4
// - Bits 2-193 carry 48 nibble-interleaved slots
// - Marker bit follows 12-frame frame/multiframe patterns
// - Frames 6, 12 rob bit 8 for signalling
// - Remote alarm forces frame 12 marker to one
// - Four-state: frames 18, 24 repeat A, B
// - Common signalling rides a 64k slot; its bit 8 is still robbed in frames 6, 12
// - Signalling as ABCD, AB or A only
// - Four groupings of twelve slots, in order
// - Group signalling channel in slots 12,24,36,48
// - Each grouping configured with or without signalling
// - Group channel carries signalling, alarms, alignment; check bit sent as one
// - Group channel takes last four grouping bits
// - Frame is 193 bits, bit 1 marker
// - 24-frame group multiframe, bit 3 alignment
// - Two-letter mode repeats A, B in C, D
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Traffic FIFO
// ----------------------------------------------------------------
module prcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Filling side
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output var logic o_in_ready,
  // Draining side
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  wire logic push = i_in_valid && o_in_ready;
  wire logic pop = o_out_valid && i_out_ready;

  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];
  assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      o_in_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // Registered ready: a word popped now frees room next cycle
      o_in_ready <= (cnt_d != CNT_FULL);
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// Transmitting framer
// ----------------------------------------------------------------
module prcm_tx (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Configuration
  input wire logic I_LAYOUT_32K,
  input wire logic I_MF24,
  input wire prcm_pkg::prcm_sig_type I_SIG_MODE,
  input wire logic [3:0] I_GRP_CAS,
  // Signalling and alarms
  input wire logic I_REMOTE_ALARM,
  input wire logic [3:0] I_GCH_ALARM,
  input wire logic [prcm_pkg::SIG_W-1:0] I_SIG_ABCD,
  // Traffic in
  input wire logic [prcm_pkg::DATA_W-1:0] I_TX_DATA,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  // Line
  prcm_link_if.tx LINK
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [14:0] acc_q;
  logic [7:0] pos_q;
  logic [4:0] mcnt_q;
  logic [4:0] gcnt_q;
  logic [7:0] sh_q;
  logic data_q;
  logic stb_q;
  logic fsync_q;
  logic [7:0] fifo_data;
  logic fifo_valid;

  // ----------------------------------------------------------------
  // Bit pacing and position decode
  // ----------------------------------------------------------------
  wire logic [14:0] acc_sum = acc_q + prcm_pkg::ACC_STEP;
  wire logic stb_w = (acc_sum >= prcm_pkg::ACC_MOD);
  wire logic [14:0] acc_d = stb_w ? acc_sum - prcm_pkg::ACC_MOD : acc_sum;
  wire logic [7:0] p_w = pos_q - 8'h01;
  wire logic [5:0] slot_w = I_LAYOUT_32K ? p_w[7:2] : {1'b0, p_w[7:3]};
  wire logic [2:0] bi_w = I_LAYOUT_32K ? {1'b0, p_w[1:0]} : p_w[2:0];
  wire logic marker_pos = (pos_q == 8'h00);
  wire logic frame_end = (pos_q == prcm_pkg::LAST_POS);
  wire logic slot_start = !marker_pos && (bi_w == 3'h0);
  wire logic [1:0] grp_w = prcm_pkg::grp_of(slot_w);
  // Groupings without signalling carry twelve traffic slots
  wire logic is_gch = I_LAYOUT_32K && I_GRP_CAS[grp_w] && prcm_pkg::gch_slot(slot_w);
  wire logic [1:0] ltr_last = I_MF24 ? prcm_pkg::LTR_LAST_24 : prcm_pkg::LTR_LAST_12;

  // ----------------------------------------------------------------
  // Marker bit
  // ----------------------------------------------------------------
  wire logic [3:0] fr12 = mcnt_q[3] ? {1'b0, mcnt_q[2:0]} + 4'h6 : {1'b0, mcnt_q[2:0]};
  wire logic fr12_last = (fr12 == prcm_pkg::MARK_LAST_IDX);
  wire logic [3:0] mark_idx = prcm_pkg::MARK_LAST_IDX - fr12;
  // 24-frame mode repeats the 12-frame marker pattern twice
  wire logic marker_w = prcm_pkg::MARK_SEQ[mark_idx] | (fr12_last && I_REMOTE_ALARM);

  // ----------------------------------------------------------------
  // Robbed-bit signalling for 64 kbit/s slots
  // ----------------------------------------------------------------
  wire logic rob_w = !I_LAYOUT_32K && (mcnt_q[2:0] == prcm_pkg::PAIR_LAST);
  wire logic [1:0] rob_ltr = prcm_pkg::eff_letter(mcnt_q[4:3], I_SIG_MODE);
  wire logic rob_bit = I_SIG_ABCD[{slot_w, rob_ltr}];
  wire logic [7:0] oct_w = fifo_valid ? fifo_data : prcm_pkg::IDLE_OCTET;

  // ----------------------------------------------------------------
  // Group signalling channel nibble
  // ----------------------------------------------------------------
  wire logic [5:0] ch1 = prcm_pkg::grp_base(grp_w) + {2'b00, gcnt_q[2:0], 1'b0};
  wire logic [5:0] ch2 = {ch1[5:1], 1'b1};
  wire logic [1:0] g_ltr = prcm_pkg::eff_letter(gcnt_q[4:3], I_SIG_MODE);
  wire logic g_pair_last = (gcnt_q[2:0] == prcm_pkg::PAIR_LAST);
  wire logic gch_b1 = I_SIG_ABCD[{ch1, g_ltr}];
  wire logic gch_b2 = g_pair_last ? I_GCH_ALARM[gcnt_q[4:3]] : I_SIG_ABCD[{ch2, g_ltr}];
  wire logic gch_b3 = gcnt_q[0] ^ gcnt_q[4];
  // Check bits and spares are sent as ones: no CRC-6 generator here
  wire logic [3:0] gch_nib = {gch_b1, gch_b2, gch_b3, 1'b1};

  // ----------------------------------------------------------------
  // Slot word selection, first bit at the MSB
  // ----------------------------------------------------------------
  wire logic [3:0] trf_nib = fifo_valid ? fifo_data[3:0] : prcm_pkg::IDLE_NIBBLE;
  wire logic [7:0] word_32 = is_gch ? {gch_nib, 4'h0} : {trf_nib, 4'h0};
  // A common signalling link is plain traffic in its slot
  wire logic [7:0] word_64 = rob_w ? {oct_w[7:1], rob_bit} : oct_w;
  wire logic [7:0] word_w = I_LAYOUT_32K ? word_32 : word_64;
  wire logic pop = stb_w && slot_start && !is_gch && fifo_valid;
  wire logic bit_w = marker_pos ? marker_w : slot_start ? word_w[7] : sh_q[7];
  wire logic [7:0] sh_d = slot_start ? {word_w[6:0], 1'b0} : {sh_q[6:0], 1'b0};

  prcm_fifo #(
    .WIDTH(prcm_pkg::DATA_W),
    .DEPTH(prcm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_in_data(I_TX_DATA),
    .i_in_valid(I_TX_VALID),
    .o_in_ready(O_TX_READY),
    .o_out_data(fifo_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      acc_q <= '0;
      pos_q <= '0;
      mcnt_q <= '0;
      gcnt_q <= '0;
      sh_q <= '0;
      data_q <= 1'b0;
      stb_q <= 1'b0;
      fsync_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      stb_q <= stb_w;
      if (stb_w) begin
        data_q <= bit_w;
        fsync_q <= marker_pos;
        sh_q <= sh_d;
        pos_q <= frame_end ? 8'h00 : pos_q + 8'h01;
        if (frame_end) begin
          mcnt_q <= prcm_pkg::mf_next(mcnt_q, ltr_last);
          gcnt_q <= prcm_pkg::mf_next(gcnt_q, prcm_pkg::LTR_LAST_24);
        end
      end else begin
        fsync_q <= 1'b0;
      end
    end
  end

  assign LINK.lnk_data = data_q;
  assign LINK.lnk_stb = stb_q;
  assign LINK.lnk_fsync = fsync_q;

endmodule
`default_nettype wire

// File: include/prcm_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Serial line between the two framers
// ----------------------------------------------------------------
interface prcm_link_if;
  logic lnk_data;
  logic lnk_stb;
  logic lnk_fsync;

  modport tx (output lnk_data, output lnk_stb, output lnk_fsync);
  modport rx (input lnk_data, input lnk_stb, input lnk_fsync);
endinterface
`default_nettype wire

// File: include/prcm_pkg.sv
// ----------------------------------------------------------------
// Shared constants and helpers for both ends of the link
// ----------------------------------------------------------------
package prcm_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 193;
  localparam logic [7:0] LAST_POS = 8'(FRAME_BITS - 1);
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int SIG_W = 192;
  localparam logic [7:0] IDLE_OCTET = 8'hFF;
  localparam logic [3:0] IDLE_NIBBLE = 4'hF;
  localparam logic [2:0] BIT_LAST_64 = 3'h7;
  localparam logic [2:0] BIT_LAST_32 = 3'h3;

  // ----------------------------------------------------------------
  // Multiframe patterns, first frame at the MSB
  // ----------------------------------------------------------------
  localparam logic [11:0] MARK_SEQ = 12'h8DC;
  localparam logic [23:0] GCH_SEQ = 24'h555AAA;
  localparam logic [3:0] MARK_LAST_IDX = 4'hB;
  localparam logic [2:0] PAIR_LAST = 3'h5;
  localparam logic [1:0] LTR_LAST_12 = 2'h1;
  localparam logic [1:0] LTR_LAST_24 = 2'h3;

  // ----------------------------------------------------------------
  // Line bit pacing: fractional divider from the system clock
  // ----------------------------------------------------------------
  localparam int LINE_KBPS = 1544;
  localparam int CLK_KHZ = 25000;
  localparam logic [14:0] ACC_STEP = 15'(LINE_KBPS);
  localparam logic [14:0] ACC_MOD = 15'(CLK_KHZ);

  typedef enum logic [1:0] {
    SIG_ABCD = 2'h0,
    SIG_AB = 2'h1,
    SIG_A = 2'h2
  } prcm_sig_type;

  typedef enum logic [1:0] {
    ST_HUNT = 2'h1,
    ST_SYNC = 2'h2
  } prcm_lock_type;

  // Letter actually sent for a position when fewer letters are in use
  function automatic logic [1:0] eff_letter(input logic [1:0] ltr, input prcm_sig_type mode);
    eff_letter = (mode == SIG_A) ? 2'h0 : (mode == SIG_AB) ? {1'b0, ltr[0]} : ltr;
  endfunction

  function automatic logic [1:0] grp_of(input logic [5:0] slot);
    grp_of = (slot >= 6'h24) ? 2'h3 : (slot >= 6'h18) ? 2'h2 : (slot >= 6'h0C) ? 2'h1 : 2'h0;
  endfunction

  function automatic logic [5:0] grp_base(input logic [1:0] grp);
    grp_base = (grp == 2'h3) ? 6'h24 : (grp == 2'h2) ? 6'h18 : (grp == 2'h1) ? 6'h0C : 6'h00;
  endfunction

  // Last slot of a grouping (zero based 11, 23, 35, 47)
  function automatic logic gch_slot(input logic [5:0] slot);
    gch_slot = (slot == 6'h0B) || (slot == 6'h17) || (slot == 6'h23) || (slot == 6'h2F);
  endfunction

  // Frame counter kept as letter (sixth) and pair (frame within sixth)
  function automatic logic [4:0] mf_next(input logic [4:0] cnt, input logic [1:0] ltr_last);
    if (cnt[2:0] != PAIR_LAST) begin
      mf_next = {cnt[4:3], cnt[2:0] + 3'h1};
    end else if (cnt[4:3] == ltr_last) begin
      mf_next = 5'h00;
    end else begin
      mf_next = {cnt[4:3] + 2'h1, 3'h0};
    end
  endfunction

endpackage
